// file: verilog/gain_amp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module gain_amp_ctrl
	import gain_amp_pkg::*;
#(
	parameter int adc_div = 4
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sync event pins
	input wire sync_events_t events_in,
	// Converter handshake
	input wire logic auto_trigger,
	input wire logic conv_done,
	output logic conv_start,
	// Analog controls
	output stage_out_t [n_stages-1:0] stage_out
);
	typedef enum logic [1:0] {
		cv_idle = 2'b00,
		cv_wait = 2'b01,
		cv_run = 2'b10
	} cv_state_t;

	typedef struct packed {
		logic [3:0] awaddr;
		logic aw_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_full;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		cv_state_t cv;
		logic [1:0] cv_sel;
		logic cv_auto;
		logic trig_seen;
		logic start;
		logic [7:0] ev_s1;
		logic [7:0] ev_s2;
		logic [7:0] ev_s3;
		logic [7:0] pre;
	} st_t;

	st_t s_q;
	st_t s_d;
	logic [7:0] ev_rise;
	logic adc_tick;
	logic [n_stages-1:0] wr_stage;
	logic [n_stages-1:0] stage_ev;
	logic [n_stages-1:0][7:0] stage_rd;
	logic busy;
	logic do_wr;
	logic sel_ev;

	assign busy = s_q.cv != cv_idle;
	assign ev_rise = s_q.ev_s2 & ~s_q.ev_s3;
	assign adc_tick = s_q.pre == 8'(adc_div - 1);
	assign do_wr = s_q.aw_full && s_q.w_full && !s_q.bvalid;
	assign sel_ev = stage_ev[s_q.cv_sel];

	// Three identical stage register blocks
	for (genvar i = 0; i < n_stages; i++) begin : g_stage
		assign wr_stage[i] = do_wr && s_q.wstrb[0] && s_q.awaddr == 4'(i * 4);
		gain_stage u_stage (
			.aclk(aclk),
			.aresetn(aresetn),
			.wr_en(wr_stage[i]),
			.wr_data(s_q.wdata[7:0]),
			.rd_data(stage_rd[i]),
			.conv_busy(busy),
			.events(ev_rise),
			.adc_tick(adc_tick),
			.sync_event(stage_ev[i]),
			.stage_out(stage_out[i])
		);
	end

	always_comb begin
		s_d = s_q;
		s_d.ev_s1 = events_in;
		s_d.ev_s2 = s_q.ev_s1;
		s_d.ev_s3 = s_q.ev_s2;
		s_d.pre = adc_tick ? 8'h00 : s_q.pre + 8'h01;
		s_d.start = 1'b0;
		if (s_axi_awvalid && !s_q.aw_full) begin
			s_d.awaddr = s_axi_awaddr;
			s_d.aw_full = 1'b1;
		end
		if (s_axi_wvalid && !s_q.w_full) begin
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
			s_d.w_full = 1'b1;
		end
		if (do_wr) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = (s_q.awaddr[1:0] == 2'b00 && s_q.awaddr <= conv_ctrl_addr) ? resp_okay : resp_slverr;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = resp_okay;
			case (s_axi_araddr)
				stage_a_addr: s_d.rdata = {24'h0, stage_rd[0]};
				stage_b_addr: s_d.rdata = {24'h0, stage_rd[1]};
				stage_c_addr: s_d.rdata = {24'h0, stage_rd[2]};
				conv_ctrl_addr: s_d.rdata = {23'h0, busy, 4'h0, s_q.cv_sel, s_q.cv_auto, 1'b0};
				default: begin
					s_d.rdata = 32'h0;
					s_d.rresp = resp_slverr;
				end
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		case (s_q.cv)
			cv_idle: begin
				if (do_wr && s_q.awaddr == conv_ctrl_addr && s_q.wstrb[0]) begin
					s_d.cv_sel = s_q.wdata[conv_sel_lo +: 2];
					s_d.cv_auto = s_q.wdata[conv_auto_bit];
					if (s_q.wdata[conv_start_bit]) begin
						s_d.cv = cv_wait;
						s_d.trig_seen = 1'b0;
					end
				end
			end
			cv_wait: begin
				// Start on the first stage event, after the trigger in auto mode
				if (sel_ev && (!s_q.cv_auto || s_q.trig_seen)) begin
					s_d.cv = cv_run;
					s_d.start = 1'b1;
				end
			end
			cv_run: begin
				if (conv_done) begin
					s_d.cv = cv_idle;
				end
			end
			default: s_d.cv = cv_idle;
		endcase
		// A trigger in the same cycle as the start write still counts
		if (auto_trigger) begin
			s_d.trig_seen = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = !s_q.aw_full;
	assign s_axi_wready = !s_q.w_full;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign conv_start = s_q.start;

	sequence wait_ev_s;
		s_q.cv == cv_wait && sel_ev && (!s_q.cv_auto || s_q.trig_seen);
	endsequence
	start_on_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wait_ev_s |=> conv_start ##1 !conv_start)
		else $error("conversion did not start on stage event");
	no_event_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.cv == cv_wait && !sel_ev) |=> !conv_start)
		else $error("conversion started without stage event");
	reg_reset_a: assert property (@(posedge aclk)
		$rose(aresetn) |-> stage_rd[2] == stage_reset)
		else $error("third stage register not reset");
	write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_wr |=> s_axi_bvalid)
		else $error("write not answered");
	trig_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		auto_trigger |=> s_q.trig_seen)
		else $error("auto trigger not captured");
	run_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.cv == cv_run && !conv_done) |=> busy)
		else $error("conversion ended without done");
	auto_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.cv == cv_wait && s_q.cv_auto && !s_q.trig_seen) |=> !conv_start)
		else $error("auto conversion started before trigger");
	read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read not answered");
	stage_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_stage[2] |=> stage_rd[2] == $past(s_q.wdata[7:0]))
		else $error("third stage write not stored");
	idle_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.cv == cv_idle) |=> !conv_start)
		else $error("conversion started from idle");
endmodule : gain_amp_ctrl
`default_nettype wire

// file: pkg/gain_amp_pkg.sv
// How it works
// - Bit 7 enables; disable waits for conversion end
// - Bit 6 shorts the differential input
// - Gain code 00/01/10/11 gives 5/10/20/40
// - Bit 3 routes output to comparator, double clock
// - Bits 2:0 pick the stage clock event
// - Amplified conversion waits for stage clock events
// - Third stage register eight bits, resets zero
// - Auto-trigger starts at next stage clock event
package gain_amp_pkg;
	localparam int n_stages = 3;
	localparam logic [3:0] stage_a_addr = 4'h0;
	localparam logic [3:0] stage_b_addr = 4'h4;
	localparam logic [3:0] stage_c_addr = 4'h8;
	localparam logic [3:0] conv_ctrl_addr = 4'hc;
	localparam logic [7:0] stage_reset = 8'h00;
	localparam int en_bit = 7;
	localparam int short_bit = 6;
	localparam int gain_hi_bit = 5;
	localparam int gain_lo_bit = 4;
	localparam int cmp_bit = 3;
	localparam int conv_start_bit = 0;
	localparam int conv_auto_bit = 1;
	localparam int conv_sel_lo = 2;
	localparam int conv_busy_bit = 8;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	localparam logic [2:0] adc_div8_last = 3'h7;
	localparam logic [7:0] gain_x5 = 8'h05;
	localparam logic [7:0] gain_x10 = 8'h0a;
	localparam logic [7:0] gain_x20 = 8'h14;
	localparam logic [7:0] gain_x40 = 8'h28;

	typedef enum logic [2:0] {
		src_adc_div8 = 3'b000,
		src_t0_compare = 3'b001,
		src_t0_overflow = 3'b010,
		src_t1_compare_b = 3'b011,
		src_t1_overflow = 3'b100,
		src_power_stage_sync_0 = 3'b101,
		src_power_stage_sync_1 = 3'b110,
		src_power_stage_sync_2 = 3'b111
	} clk_src_t;

	typedef struct packed {
		logic on;
		logic input_short;
		logic [1:0] gain;
		logic to_comparator;
		clk_src_t clksel;
	} stage_ctrl_t;

	// Event inputs, one bit per source code
	typedef struct packed {
		logic power_stage_sync_2;
		logic power_stage_sync_1;
		logic power_stage_sync_0;
		logic t1_overflow;
		logic t1_compare_b;
		logic t0_overflow;
		logic t0_compare;
		logic adc_clk;
	} sync_events_t;

	// Analog switch controls for one stage
	typedef struct packed {
		logic powered;
		logic input_short;
		logic [7:0] gain;
		logic to_comparator;
		logic amp_clk;
		logic cmp_clk;
	} stage_out_t;

	function automatic logic [7:0] gain_value(input logic [1:0] code);
		case (code)
			2'b00: gain_value = gain_x5;
			2'b01: gain_value = gain_x10;
			2'b10: gain_value = gain_x20;
			default: gain_value = gain_x40;
		endcase
	endfunction : gain_value
endpackage : gain_amp_pkg

// file: verilog/gain_stage.sv
`timescale 1ns/1ps
`default_nettype none
module gain_stage
	import gain_amp_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register access
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	// Conversion and event inputs
	input wire logic conv_busy,
	input wire logic [7:0] events,
	input wire logic adc_tick,
	// Outputs
	output logic sync_event,
	output stage_out_t stage_out
);
	typedef struct packed {
		stage_ctrl_t ctrl;
		logic on_eff;
		logic [2:0] div;
		logic amp_clk;
		logic cmp_clk;
		logic event_q;
	} st_t;

	st_t s_q;
	st_t s_d;
	logic ev;

	always_comb begin
		s_d = s_q;
		if (wr_en) begin
			s_d.ctrl = stage_ctrl_t'(wr_data);
		end
		// Disable held off while a conversion runs
		if (s_d.ctrl.on || !conv_busy) begin
			s_d.on_eff = s_d.ctrl.on;
		end
		if (adc_tick) begin
			s_d.div = s_q.div + 3'h1;
		end
		ev = (s_q.ctrl.clksel == src_adc_div8) ? (adc_tick && s_q.div == adc_div8_last)
			: events[s_q.ctrl.clksel];
		s_d.event_q = ev && s_q.on_eff;
		if (s_d.event_q) begin
			s_d.amp_clk = !s_q.amp_clk;
		end
		// Comparator clock pulses once per event: twice the stage rate
		s_d.cmp_clk = s_d.event_q && s_q.ctrl.to_comparator;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '{ctrl: stage_ctrl_t'(stage_reset), on_eff: 1'b0, div: 3'h0,
				amp_clk: 1'b0, cmp_clk: 1'b0, event_q: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.ctrl;
	assign sync_event = s_q.event_q;
	assign stage_out.powered = s_q.on_eff;
	assign stage_out.input_short = s_q.ctrl.input_short;
	assign stage_out.gain = gain_value(s_q.ctrl.gain);
	assign stage_out.to_comparator = s_q.ctrl.to_comparator;
	assign stage_out.amp_clk = s_q.amp_clk;
	assign stage_out.cmp_clk = s_q.cmp_clk;

	hold_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.on_eff && conv_busy && !s_d.ctrl.on) |=> s_q.on_eff)
		else $error("stage switched off during conversion");
	gain_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.ctrl.gain == 2'b11) |-> (stage_out.gain == gain_x40))
		else $error("gain code 11 not mapped to 40");
	event_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!s_q.on_eff |=> !sync_event)
		else $error("event from disabled stage");
	cmp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!s_q.ctrl.to_comparator |=> !s_q.cmp_clk)
		else $error("comparator clock moved while unrouted");
endmodule : gain_stage
`default_nettype wire

// file: sim/gain_amplifier_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gain_amplifier_control_bench
	import gain_amp_pkg::*;
;
	logic aclk, aresetn;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic auto_trigger, conv_done, conv_start;
	sync_events_t events_in;
	stage_out_t [n_stages-1:0] stage_out;
	int miscompares, checks_done, cyc;
	logic [31:0] rv;
	logic [1:0] rr;
	logic a;
	bit seen;

	gain_amp_ctrl #(.adc_div(2)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .events_in, .auto_trigger, .conv_done, .conv_start, .stage_out);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask : chk

	task idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle

	task wr(input logic [3:0] ad, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] ad);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Pulse one event line (8 means none) and watch for a start
	task ev(input int b, input int n);
		@(posedge aclk);
		events_in <= sync_events_t'(8'h01 << b);
		seen = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			if (i == 2) events_in <= '0;
			if (conv_start === 1'b1) seen = 1;
		end
	endtask : ev

	task end_conv;
		@(posedge aclk);
		conv_done <= 1'b1;
		@(posedge aclk);
		conv_done <= 1'b0;
		idle(3);
	endtask : end_conv

	task t_regs;
		rd(stage_c_addr);
		chk(rv, 32'h0, "c reset");
		chk(rr, resp_okay, "read okay");
		wr(stage_c_addr, 8'hff);
		chk(rr, resp_okay, "write okay");
		rd(stage_c_addr);
		chk(rv, 32'hff, "c rw");
		rd(stage_b_addr);
		chk(rv, 32'h0, "b apart");
		wr(stage_b_addr, 8'h24);
		rd(stage_b_addr);
		chk(rv, 32'h24, "b rw");
		rd(stage_c_addr);
		chk(rv, 32'hff, "c kept");
		wr(stage_b_addr, 8'h00);
		wr(stage_c_addr, 8'h00);
		rd(4'h2);
		chk(rr, resp_slverr, "unaligned");
		$display("test regs done");
	endtask : t_regs

	task t_fields;
		for (int g = 0; g < 4; g++) begin
			wr(stage_c_addr, 8'hc8 | 8'(g << 4));
			idle(128);
			chk(stage_out[2].powered, 1, "on");
			chk(stage_out[2].input_short, 1, "short");
			chk(stage_out[2].to_comparator, 1, "cmp");
			chk(stage_out[2].gain, g == 0 ? gain_x5 : g == 1 ? gain_x10 : g == 2 ? gain_x20 : gain_x40, "gain");
			chk(stage_out[1].powered, 0, "b off");
		end
		wr(stage_c_addr, 8'h00);
		idle(3);
		chk({stage_out[2].powered, stage_out[2].input_short, stage_out[2].to_comparator}, 0, "clear");
		$display("test fields done");
	endtask : t_fields

	task t_src;
		int n, m;
		logic p;
		for (int c = 1; c < 8; c++) begin
			wr(stage_c_addr, 8'h80 | 8'(c));
			idle(2);
			a = stage_out[2].amp_clk;
			ev(c, 8);
			chk(stage_out[2].amp_clk, !a, "src");
			ev(c == 7 ? 1 : c + 1, 8);
			chk(stage_out[2].amp_clk, !a, "other");
		end
		wr(stage_c_addr, 8'h88);
		n = 0;
		m = 0;
		a = stage_out[2].amp_clk;
		p = stage_out[2].cmp_clk;
		repeat (160) begin
			@(posedge aclk);
			if (stage_out[2].amp_clk !== a) n++;
			if (stage_out[2].cmp_clk === 1'b1 && p === 1'b0) m++;
			a = stage_out[2].amp_clk;
			p = stage_out[2].cmp_clk;
		end
		chk(n inside {[9:11]}, 1, "div8");
		chk(m, n, "cmp twice");
		wr(stage_c_addr, 8'h00);
		$display("test sources done");
	endtask : t_src

	task t_conv;
		wr(stage_c_addr, 8'h81);
		wr(conv_ctrl_addr, 8'h09);
		ev(8, 20);
		chk(seen, 0, "no event");
		ev(1, 12);
		chk(seen, 1, "start");
		rd(conv_ctrl_addr);
		chk(rv[conv_busy_bit], 1, "busy");
		wr(stage_c_addr, 8'h00);
		idle(3);
		chk(stage_out[2].powered, 1, "held");
		end_conv;
		chk(stage_out[2].powered, 0, "off");
		$display("test conversion done");
	endtask : t_conv

	task t_auto;
		wr(stage_c_addr, 8'h81);
		wr(conv_ctrl_addr, 8'h0b);
		ev(1, 12);
		chk(seen, 0, "no trig");
		@(posedge aclk);
		auto_trigger <= 1'b1;
		@(posedge aclk);
		auto_trigger <= 1'b0;
		ev(8, 12);
		chk(seen, 0, "no clk");
		ev(1, 12);
		chk(seen, 1, "auto start");
		end_conv;
		wr(stage_c_addr, 8'h00);
		$display("test auto done");
	endtask : t_auto

	task end_sim;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			end_sim;
		end
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'h1;
		{auto_trigger, conv_done} = '0;
		events_in = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_fields;
		t_src;
		t_conv;
		t_auto;
		end_sim;
	end
endmodule : gain_amplifier_control_bench
`default_nettype wire
